// File: common/i2c_pin_mode_map.svh
/*
 Offsets, field positions and reset values of the pin-control
 and mode registers. Assumes a 12-bit APB byte address.
*/
`ifndef I2C_PIN_MODE_MAP_SVH
`define I2C_PIN_MODE_MAP_SVH

// Register byte offsets
`define CTL2_OFS      12'h000
`define MODE_OFS      12'h004

// Control-two field positions
`define CTL2_SDA_VAL  5
`define CTL2_SDA_WG   4
`define CTL2_SCL_MON  3
`define CTL2_RSV2     2
`define CTL2_SOFT_RST 1
`define CTL2_RSV0     0

// Mode field positions
`define MODE_ORDER    7
`define MODE_RSV6     6
`define MODE_CNT_WG   3
`define MODE_CNT_HI   2

// Reset values
`define MODE_RST      8'h38
`define CTL2_SDA_RST  1'b1
`define CNT_RST       3'h0

`endif

// File: common/i2c_pin_mode_pkg.sv
/*
 Types shared by the pin-control and mode register block.
 Assumes the map header for all numbers.
*/
package i2c_pin_mode_pkg;

    // APB slave phase, Gray along idle to wait
    typedef enum logic [0:0] {
        APB_IDLE = 1'b0,
        APB_WAIT = 1'b1
    } apb_state_e;

    // One byte-wide register image
    typedef logic [7:0] reg8_t;

endpackage : i2c_pin_mode_pkg

// File: rtl/bit_count_keeper.sv
/*
 Three-bit remaining-transfer counter with clear, guarded load
 and count-down. Assumes all controls come from core_clk_in.
*/
`timescale 1ns/10ps
`include "i2c_pin_mode_map.svh"

module bit_count_keeper #(
    parameter int CNT_W = 3
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             clear_in,
    input  wire logic             load_in,
    input  wire logic [CNT_W-1:0] load_val_in,
    input  wire logic             step_in,
    output logic      [CNT_W-1:0] count_out
);

    logic [CNT_W-1:0] count;      // Remaining bits
    logic [CNT_W-1:0] next_count; // Next remaining bits

    // Clear beats load beats step
    always_comb begin
        next_count = count;
        if (clear_in) begin
            // RL12 clear to zero
            next_count = '0;
        end else if (load_in) begin
            next_count = load_val_in;
        end else if (step_in && (count != '0)) begin
            // Stops at zero, never wraps
            next_count = count - CNT_W'(1);
        end
    end

    // Register only
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count <= CNT_W'(`CNT_RST);
        end else begin
            count <= next_count;
        end
    end

    assign count_out = count;

endmodule : bit_count_keeper

// File: rtl/i2c_pin_mode_regs.sv
/*
 Pin-control and mode registers of a two-wire serial interface,
 reached over APB, with the transfer-counter keeper inside.
 Assumes the transfer engine runs on core_clk_in and that the
 SDA and SCL wires have external pull-ups.
*/
//
// Contract
// RL1 - SDA level changes only with guard 0
// RL2 - Read-only bit shows SCL output level
// RL3 - Control bits 2, 0 read one
// RL4 - Soft reset clears control, keeps registers
// RL5 - Software uses soft reset after hang-up
// RL6 - Mode register is 8-bit read/write
// RL7 - Power-on reset loads mode with 38
// RL8 - Mode bit 7 selects bit order
// RL9 - Software writes zero to mode bit 6
// RL10 - Counter loads only with guard 0
// RL11 - SDA value 0 drives low, 1 releases
// RL12 - Counter cleared by resets and standby
`timescale 1ns/10ps
`include "i2c_pin_mode_map.svh"

module i2c_pin_mode_regs
    import i2c_pin_mode_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int CNT_W  = 3
) (
    input  wire logic              core_clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic      [31:0]       prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    input  wire logic              scl_level_in,
    input  wire logic              standby_in,
    input  wire logic              bit_step_in,
    output logic                   sda_o_out,
    output logic                   sda_oe_out,
    output logic                   scl_o_out,
    output logic                   scl_oe_out,
    output logic                   bit_order_lsb_out,
    output logic                   soft_reset_out,
    output logic      [CNT_W-1:0]  bit_count_out
);

    apb_state_e       state;          // Bus phase
    apb_state_e       next_state;     // Next bus phase
    logic [31:0]      rdata;          // Latched read word
    logic [31:0]      next_rdata;     // Read word to latch
    logic             sda_level_value;      // Driven SDA level
    logic             next_sda_level_value; // Next SDA level
    logic             bit_order_select;     // 1 is LSB first
    logic             next_bit_order_select;
    logic             soft_pulse;     // Control-part reset
    logic             next_soft_pulse;
    logic             done;           // Transfer completes
    logic             hit_ctl2;       // Control-two decoded
    logic             hit_mode;       // Mode decoded
    logic             wr_ctl2;        // Control-two write
    logic             wr_mode;        // Mode write
    logic             cnt_load;       // Guarded counter load
    logic [CNT_W-1:0] transfer_bit_counter; // Remaining bits
    reg8_t            ctl2_view;      // Control-two read image
    reg8_t            mode_view;      // Mode read image

    // Address decode, full match only
    assign hit_ctl2 = (paddr_in == ADDR_W'(`CTL2_OFS));
    assign hit_mode = (paddr_in == ADDR_W'(`MODE_OFS));

    // Handshake is combinational, one wait state always
    assign pready_out  = (state == APB_WAIT);
    assign done        = psel_in && penable_in && pready_out;
    assign pslverr_out = pready_out && !(hit_ctl2 || hit_mode);
    assign wr_ctl2     = done && pwrite_in && hit_ctl2;
    assign wr_mode     = done && pwrite_in && hit_mode;

    // Control-two image; bits 7 and 6 belong to start logic
    always_comb begin
        ctl2_view = 8'h00;
        ctl2_view[`CTL2_SDA_VAL] = sda_level_value;
        // RL1 guard reads one
        ctl2_view[`CTL2_SDA_WG] = 1'b1;
        // RL2 live SCL level
        ctl2_view[`CTL2_SCL_MON] = scl_level_in;
        // RL3 reserved read one
        ctl2_view[`CTL2_RSV2] = 1'b1;
        ctl2_view[`CTL2_RSV0] = 1'b1;
        // Soft reset is a pulse, so it reads zero
        ctl2_view[`CTL2_SOFT_RST] = 1'b0;
    end

    // Mode image; bits 5 and 4 and the guard read one
    always_comb begin
        mode_view = 8'h00;
        // RL8 order bit readback
        mode_view[`MODE_ORDER] = bit_order_select;
        // Bit 6 is not stored, reads zero
        mode_view[`MODE_RSV6] = 1'b0;
        mode_view[5] = 1'b1;
        mode_view[4] = 1'b1;
        // RL10 guard reads one
        mode_view[`MODE_CNT_WG] = 1'b1;
        mode_view[`MODE_CNT_HI:0] = transfer_bit_counter;
    end

    // Bus phase and read latch
    always_comb begin
        next_state = state;
        next_rdata = rdata;
        unique case (state)
            APB_IDLE: begin
                // Latch in first access cycle
                if (psel_in && penable_in) begin
                    next_state = APB_WAIT;
                    next_rdata = 32'h0000_0000;
                    if (!pwrite_in && hit_ctl2) begin
                        next_rdata = {24'h00_0000, ctl2_view};
                    end else if (!pwrite_in && hit_mode) begin
                        // RL6 upper bits zero
                        next_rdata = {24'h00_0000, mode_view};
                    end
                end
            end
            APB_WAIT: begin
                // Access ends here; data held until the next access latches
                next_state = APB_IDLE;
            end
        endcase
    end

    // Register only
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= APB_IDLE;
            rdata <= 32'h0000_0000;
        end else begin
            state <= next_state;
            rdata <= next_rdata;
        end
    end

    assign prdata_out = rdata;

    // Register updates on completed writes
    always_comb begin
        next_sda_level_value  = sda_level_value;
        next_bit_order_select = bit_order_select;
        next_soft_pulse       = 1'b0;
        // RL1 guarded SDA write
        if (wr_ctl2 && !pwdata_in[`CTL2_SDA_WG]) begin
            next_sda_level_value = pwdata_in[`CTL2_SDA_VAL];
        end
        // RL4 soft reset pulse
        if (wr_ctl2 && pwdata_in[`CTL2_SOFT_RST]) begin
            next_soft_pulse = 1'b1;
        end
        // RL8 order bit write
        if (wr_mode) begin
            next_bit_order_select = pwdata_in[`MODE_ORDER];
        end
    end

    // Register only; the soft pulse leaves these alone
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sda_level_value  <= `CTL2_SDA_RST;
            // RL7 order bit of 38
            bit_order_select <= 1'(`MODE_RST >> `MODE_ORDER);
            soft_pulse       <= 1'b0;
        end else begin
            sda_level_value  <= next_sda_level_value;
            bit_order_select <= next_bit_order_select;
            soft_pulse       <= next_soft_pulse;
        end
    end

    // RL10 load needs guard 0
    assign cnt_load = wr_mode && !pwdata_in[`MODE_CNT_WG];

    // Counter keeper; clears win over a load in the same cycle
    bit_count_keeper #(
        .CNT_W       (CNT_W)
    ) u_bit_count_keeper (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .clear_in    (soft_pulse || standby_in),
        .load_in     (cnt_load),
        .load_val_in (pwdata_in[CNT_W-1:0]),
        .step_in     (bit_step_in),
        .count_out   (transfer_bit_counter)
    );

    // RL11 open-drain SDA
    assign sda_o_out  = 1'b0;
    assign sda_oe_out = !sda_level_value;
    // SCL is open-drain too; engine gives the wanted level
    assign scl_o_out  = 1'b0;
    assign scl_oe_out = !scl_level_in;

    assign bit_order_lsb_out = bit_order_select;
    assign soft_reset_out    = soft_pulse;
    assign bit_count_out     = transfer_bit_counter;

    // Helper: mode untouched since reset
    logic mode_clean;
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_clean <= 1'b1;
        end else if (wr_mode || bit_step_in || standby_in) begin
            mode_clean <= 1'b0;
        end
    end

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // Named steps of control-two writes and of register reads
    sequence s_sda_write;
        wr_ctl2 && !pwdata_in[`CTL2_SDA_WG];
    endsequence

    sequence s_soft_write;
        wr_ctl2 && pwdata_in[`CTL2_SOFT_RST];
    endsequence

    sequence s_ctl2_read;
        state == APB_IDLE && psel_in && penable_in
            && !pwrite_in && hit_ctl2;
    endsequence

    sequence s_mode_read;
        state == APB_IDLE && psel_in && penable_in
            && !pwrite_in && hit_mode;
    endsequence

    property p_sda_guarded;
        s_sda_write |=> sda_level_value == $past(pwdata_in[5]);
    endproperty
    a_sda_guarded: assert property (p_sda_guarded) // RL1
        else $error("SDA level not taken on guarded write");

    property p_sda_protect;
        wr_ctl2 && pwdata_in[`CTL2_SDA_WG] |=> $stable(sda_oe_out);
    endproperty
    a_sda_protect: assert property (p_sda_protect) // RL1
        else $error("SDA level changed with guard set");

    property p_guard_one;
        s_ctl2_read |=> prdata_out[4] && pready_out;
    endproperty
    a_guard_one: assert property (p_guard_one) // RL1
        else $error("SDA guard did not read one");

    property p_scl_mon;
        s_ctl2_read |=> prdata_out[3] == $past(scl_level_in)
            && prdata_out[3] == !$past(scl_oe_out);
    endproperty
    a_scl_mon: assert property (p_scl_mon) // RL2
        else $error("SCL monitor does not match SCL level");

    property p_rsv_one;
        s_ctl2_read |=> prdata_out[2] && prdata_out[0];
    endproperty
    a_rsv_one: assert property (p_rsv_one) // RL3
        else $error("Reserved control bits not one");

    // Same write may move SDA legally; the pulse cycle must not
    property p_soft;
        s_soft_write |=> soft_reset_out
            ##1 !soft_reset_out && bit_count_out == 3'h0
            && $stable(sda_level_value) && $stable(bit_order_select);
    endproperty
    a_soft: assert property (p_soft) // RL4
        else $error("Soft reset wrong or touched registers");

    property p_mode_width;
        s_mode_read |=> prdata_out[31:8] == 24'h00_0000
            && prdata_out[2:0] == $past(bit_count_out);
    endproperty
    a_mode_width: assert property (p_mode_width) // RL6
        else $error("Mode read image wrong");

    property p_mode_rst;
        mode_clean |-> mode_view == `MODE_RST;
    endproperty
    a_mode_rst: assert property (p_mode_rst) // RL7
        else $error("Mode not at reset value");

    property p_order;
        wr_mode |=> bit_order_lsb_out == $past(pwdata_in[7]);
    endproperty
    a_order: assert property (p_order) // RL8
        else $error("Bit order not taken");

    property p_cnt_load;
        cnt_load && !soft_pulse && !standby_in
            |=> bit_count_out == $past(pwdata_in[2:0]);
    endproperty
    a_cnt_load: assert property (p_cnt_load) // RL10
        else $error("Counter load missed");

    property p_cnt_guard;
        wr_mode && pwdata_in[3] && !soft_pulse && !standby_in
            && !bit_step_in |=> $stable(bit_count_out);
    endproperty
    a_cnt_guard: assert property (p_cnt_guard) // RL10
        else $error("Counter changed with guard set");

    property p_sda_pin;
        s_sda_write |=> sda_oe_out == !$past(pwdata_in[5])
            && !sda_o_out;
    endproperty
    a_sda_pin: assert property (p_sda_pin) // RL11
        else $error("SDA pin drive wrong");

    property p_standby;
        standby_in |=> bit_count_out == 3'h0;
    endproperty
    a_standby: assert property (p_standby) // RL12
        else $error("Counter not cleared by standby");

endmodule : i2c_pin_mode_regs

// File: bench/bus_peer_model.sv
/*
 Far side of the two-wire bus: other devices plus pull-ups.
 Assumes open-drain drivers; a peer may hold SDA low.
*/
`timescale 1ns/10ps

module bus_peer_model (
    input  wire logic sda_o_in,
    input  wire logic sda_oe_in,
    input  wire logic scl_o_in,
    input  wire logic scl_oe_in,
    input  wire logic peer_hold_sda_in,
    output logic      sda_line_out,
    output logic      scl_line_out
);
    // Wired AND: any enabled low driver wins, pull-up otherwise
    assign sda_line_out = !((sda_oe_in && !sda_o_in) || peer_hold_sda_in);
    // Only the block drives SCL here; released line goes high
    assign scl_line_out = !(scl_oe_in && !scl_o_in);
endmodule : bus_peer_model

// File: bench/tb.sv
/*
 Self-checking bench for the pin-control and mode registers.
 Assumes APB with one wait state and pulled-up bus wires.
*/
`timescale 1ns/10ps
`include "i2c_pin_mode_map.svh"

module tb
    import i2c_pin_mode_pkg::*;
;
    // Compare, count and report at once
    `define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin \
        mismatches++; $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
    logic        core_clk_in = 1'b0;  // 40 MHz
    logic        rst_n_in    = 1'b0;
    logic        psel_in     = 1'b0;
    logic        penable_in  = 1'b0;
    logic        pwrite_in   = 1'b0;
    logic [11:0] paddr_in    = 12'h000;
    logic [31:0] pwdata_in   = 32'h0;
    logic        scl_level_in = 1'b1;
    logic        standby_in  = 1'b0;
    logic        bit_step_in = 1'b0;
    logic        hold_sda    = 1'b0;  // Peer pulls SDA low
    logic [31:0] prdata_out;
    logic        pready_out, pslverr_out, sda_o_out, sda_oe_out;
    logic        scl_o_out, scl_oe_out, bit_order_lsb_out;
    logic        soft_reset_out, sda_line, scl_line;
    logic [2:0]  bit_count_out;
    int          mismatches = 0;
    int          check_count = 0;

    always #12.5 core_clk_in = !core_clk_in;

    i2c_pin_mode_regs u_i2c_pin_mode_regs (.core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .scl_level_in(scl_level_in),
        .standby_in(standby_in), .bit_step_in(bit_step_in),
        .sda_o_out(sda_o_out), .sda_oe_out(sda_oe_out),
        .scl_o_out(scl_o_out), .scl_oe_out(scl_oe_out),
        .bit_order_lsb_out(bit_order_lsb_out),
        .soft_reset_out(soft_reset_out), .bit_count_out(bit_count_out));

    bus_peer_model u_bus_peer_model (.sda_o_in(sda_o_out),
        .sda_oe_in(sda_oe_out), .scl_o_in(scl_o_out),
        .scl_oe_in(scl_oe_out), .peer_hold_sda_in(hold_sda),
        .sda_line_out(sda_line), .scl_line_out(scl_line));

    // One APB transfer; holds everything until pready is seen or 20 more edges pass
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        @(posedge core_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        // Pready is judged only at rising edges
        @(posedge core_clk_in);
        while (pready_out !== 1'b1 && n < 20) begin
            @(posedge core_clk_in);
            n++;
        end
        `CHK("pready", 1'b1, pready_out)
        e = pslverr_out;
        r = prdata_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        // Let registered outputs settle before callers look
        @(negedge core_clk_in);
    endtask : apb

    // Write then read back one register
    task automatic wr_rd(input logic [11:0] a, input logic [31:0] d,
                         output logic [31:0] r);
        logic e;
        apb(1'b1, a, d, r, e);
        apb(1'b0, a, 32'h0, r, e);
    endtask : wr_rd

    task automatic t_reset_vals;
        logic [31:0] r;
        logic e;
        apb(1'b0, `MODE_OFS, 32'h0, r, e);
        `CHK("mode reset", 32'h0000_0038, r)
        `CHK("mode rd okay", 1'b0, e)
        apb(1'b0, `CTL2_OFS, 32'h0, r, e);
        `CHK("ctl2 reset", 32'h0000_003D, r)
        `CHK("count reset", 3'h0, bit_count_out)
    endtask : t_reset_vals

    task automatic t_sda;
        logic [31:0] r;
        // Guard kept at 1: level must not move
        wr_rd(`CTL2_OFS, 32'h0000_0010, r);
        `CHK("sda guarded", 1'b1, sda_line)
        `CHK("ctl2 guarded", 32'h0000_003D, r)
        // Guard cleared, reserved bits written 0
        wr_rd(`CTL2_OFS, 32'h0000_0000, r);
        `CHK("sda low", 1'b0, sda_line)
        `CHK("ctl2 low", 32'h0000_001D, r)
        wr_rd(`CTL2_OFS, 32'h0000_0020, r);
        `CHK("sda released", 1'b0, sda_oe_out)
        `CHK("sda high", 1'b1, sda_line)
        `CHK("sda o", 1'b0, sda_o_out)
        // peer may still pull a released line
        @(posedge core_clk_in);
        hold_sda <= 1'b1;
        @(negedge core_clk_in);
        `CHK("sda peer low", 1'b0, sda_line)
        `CHK("sda still off", 1'b0, sda_oe_out)
        @(posedge core_clk_in);
        hold_sda <= 1'b0;
    endtask : t_sda

    task automatic t_scl;
        logic [31:0] r;
        logic e;
        @(posedge core_clk_in);
        scl_level_in <= 1'b0;
        apb(1'b0, `CTL2_OFS, 32'h0, r, e);
        `CHK("scl mon low", 32'h0000_0035, r)
        `CHK("scl line", 1'b0, scl_line)
        `CHK("scl oe", 1'b1, scl_oe_out)
        @(posedge core_clk_in);
        scl_level_in <= 1'b1;
    endtask : t_scl

    task automatic t_mode;
        logic [31:0] r;
        // Bit 6 written 0 always by software
        wr_rd(`MODE_OFS, 32'h0000_008D, r);
        `CHK("cnt guarded", 32'h0000_00B8, r)
        `CHK("order lsb", 1'b1, bit_order_lsb_out)
        wr_rd(`MODE_OFS, 32'h0000_0085, r);
        `CHK("cnt loaded", 32'h0000_00BD, r)
        `CHK("cnt out", 3'h5, bit_count_out)
        @(posedge core_clk_in);
        standby_in <= 1'b1;
        @(posedge core_clk_in);
        standby_in <= 1'b0;
        @(negedge core_clk_in);
        `CHK("standby clr", 3'h0, bit_count_out)
        wr_rd(`MODE_OFS, 32'h0000_0007, r);
        `CHK("mode 07", 32'h0000_003F, r)
        `CHK("order msb", 1'b0, bit_order_lsb_out)
        @(posedge core_clk_in);
        bit_step_in <= 1'b1;
        @(posedge core_clk_in);
        bit_step_in <= 1'b0;
        @(negedge core_clk_in);
        `CHK("step", 3'h6, bit_count_out)
    endtask : t_mode

    // Hang-up recovery keeps registers, clears counter
    task automatic t_soft;
        logic [31:0] r;
        logic e;
        wr_rd(`MODE_OFS, 32'h0000_0085, r);
        apb(1'b1, `CTL2_OFS, 32'h0, r, e);
        // Software recovery write
        apb(1'b1, `CTL2_OFS, 32'h0000_0012, r, e);
        `CHK("soft pulse", 1'b1, soft_reset_out)
        @(negedge core_clk_in);
        `CHK("soft clr", 3'h0, bit_count_out)
        `CHK("sda kept", 1'b0, sda_line)
        apb(1'b0, `MODE_OFS, 32'h0, r, e);
        `CHK("mode kept", 32'h0000_00B8, r)
        apb(1'b0, `CTL2_OFS, 32'h0, r, e);
        `CHK("soft reads 0", 32'h0000_001D, r)
        apb(1'b1, `CTL2_OFS, 32'h0000_0020, r, e);
    endtask : t_soft

    task automatic t_unmapped;
        logic [31:0] r;
        logic e;
        apb(1'b1, 12'h008, 32'h0000_00FF, r, e);
        `CHK("wr slverr", 1'b1, e)
        apb(1'b0, 12'h008, 32'h0, r, e);
        `CHK("rd zero", 32'h0, r)
        apb(1'b0, `MODE_OFS, 32'h0, r, e);
        `CHK("mode intact", 32'h0000_00B8, r)
    endtask : t_unmapped

    // Single verdict point
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    // Whole run is about 120 cycles; limit lies at 5000 cycles
    initial begin
        #(5000 * 25);
        mismatches++;
        wrap_up();
    end

    initial begin
        repeat (2) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        t_reset_vals();
        t_sda();
        t_scl();
        t_mode();
        t_soft();
        t_unmapped();
        wrap_up();
    end
endmodule : tb
